/* rtl/lssd_top.sv */
// Lane squelch and disable control for an optical transceiver module.
// Assumes control values come from the management register core on
// clk_in; bus pins and analog detector outputs are asynchronous.
`timescale 1ns/1ps

module lssd_top #(
    parameter int MS_CYCLES = lssd_pkg::MS_CYC_DEF // Cycles per ms
) (
    // Clock and reset
    input  wire logic                        clk_in,
    input  wire logic                        rst_in,
    // Two-wire management bus pins
    input  wire logic                        scl_in,
    input  wire logic                        sda_in,
    input  wire logic                        module_select_n_in,
    // Host control values from the register core
    input  wire logic [lssd_pkg::N_LANE-1:0] tx_disable_in,
    input  wire logic [lssd_pkg::N_LANE-1:0] rx_out_disable_in,
    input  wire logic                        rx_sq_disable_in,
    input  wire logic                        tx_sq_disable_in,
    input  wire logic                        tx_miss_clr_in,
    // Module capabilities and configuration
    input  wire logic                        fast_mode_adv_in,
    input  wire logic                        mgmt_rev4_in,
    input  wire logic                        off_by_power_in,
    input  wire logic [1:0]                  rate_class_in,
    input  wire lssd_pkg::lssd_ms_t          advertised_tx_off_limit_in,
    input  wire lssd_pkg::lssd_ms_t          advertised_tx_on_limit_in,
    // Analog detectors
    input  wire logic [lssd_pkg::N_PORT-1:0] rx_los_in,
    input  wire logic [lssd_pkg::N_LANE-1:0] tx_amp_low_in,
    input  wire logic [lssd_pkg::N_LANE-1:0] tx_power_ok_in,
    // Lane drivers
    output logic [lssd_pkg::N_LANE-1:0]      rx_out_en_out,
    output logic [lssd_pkg::N_LANE-1:0]      tx_laser_off_out,
    output logic [lssd_pkg::N_LANE-1:0]      tx_low_oma_out,
    output logic [7:0]                       tx_sq_threshold_out,
    // Status
    output logic [lssd_pkg::N_LANE-1:0]      tx_input_loss_flag_out,
    output logic                             tx_busy_out,
    output logic                             tx_miss_out
);
    import lssd_pkg::*;

    // ****************************************************
    // Functions
    // ****************************************************
    // Effective limit: advertised value on rev4 modules, clamped to the fixed one; otherwise the fixed one
    function automatic lssd_ms_t eff_limit(input lssd_ms_t adv,
                                           input lssd_ms_t fixed,
                                           input logic     rev4);
        eff_limit = (rev4 && adv < fixed) ? adv : fixed;
    endfunction : eff_limit

    // ****************************************************
    // Declarations
    // ****************************************************
    logic [N_SYNC-1:0] s1_ff;            // First sync stage
    logic [N_SYNC-1:0] s2_ff;            // Second sync stage
    logic              scl_s;            // Synced clock line
    logic              sda_s;            // Synced data line
    logic              msel_n_s;         // Synced module select
    logic [N_PORT-1:0] los_s;            // Synced Rx loss
    logic [N_LANE-1:0] amp_low_s;        // Synced Tx amplitude low
    logic [N_LANE-1:0] pwr_ok_s;         // Synced laser power good
    logic              sda_d_ff;         // Previous data line
    logic              stop_w;           // STOP seen while selected
    logic [N_LANE-1:0] tx_dis_ff;        // Committed Tx disable
    logic [N_LANE-1:0] rx_odis_ff;       // Committed Rx disable
    logic              rx_sqdis_ff;      // Committed Rx squelch off
    logic              tx_sqdis_ff;      // Committed Tx squelch off
    logic [31:0]       div_ff;           // Millisecond divider
    logic              tick_ff;          // Millisecond enable
    lssd_ms_t          flt_ff [N_LANE];  // Tx loss filter counts
    logic [N_LANE-1:0] loss_ff;          // Filtered Tx loss
    logic [N_LANE-1:0] rx_sq_w;          // Rx lane squelch request
    logic [N_LANE-1:0] tx_sq_w;          // Tx output squelch request
    logic [N_LANE-1:0] rx_en_ff;         // Rx driver enables
    logic [N_LANE-1:0] off_ff;           // Laser off controls
    logic [N_LANE-1:0] oma_ff;           // Low amplitude controls
    logic [7:0]        thr_ff;           // Squelch threshold
    lssd_ms_t          lim_ff;           // Current deadline
    logic              start_ff;         // Watch start pulse
    logic              busy_ff;          // Watch running copy
    logic              miss_ff;          // Sticky deadline miss

    lssd_dl_if dl ();

    // ****************************************************
    // Pin synchronisers
    // ****************************************************
    // Two flops for every asynchronous input
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s1_ff <= {3'h7, {(N_SYNC-3){1'b0}}};
            s2_ff <= {3'h7, {(N_SYNC-3){1'b0}}};
        end else begin
            s1_ff <= {scl_in, sda_in, module_select_n_in,
                      rx_los_in, tx_amp_low_in, tx_power_ok_in};
            s2_ff <= s1_ff;
        end
    end

    assign {scl_s, sda_s, msel_n_s, los_s, amp_low_s, pwr_ok_s} = s2_ff;

    // ****************************************************
    // STOP detection and control commit
    // ****************************************************
    // Previous data line for edge finding
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            sda_d_ff <= 1'b1;
        end else begin
            sda_d_ff <= sda_s;
        end
    end

    // Data rising while clock high; only counted when selected
    assign stop_w = scl_s && sda_s && !sda_d_ff && !msel_n_s;

    // Controls take effect at the STOP that ends the write
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            tx_dis_ff   <= '0;
            rx_odis_ff  <= '0;
            rx_sqdis_ff <= 1'b0;
            tx_sqdis_ff <= 1'b0;
        end else if (stop_w) begin
            tx_dis_ff   <= tx_disable_in;
            rx_odis_ff  <= rx_out_disable_in;
            rx_sqdis_ff <= rx_sq_disable_in;
            tx_sqdis_ff <= tx_sq_disable_in;
        end
    end

    // ****************************************************
    // Millisecond tick
    // ****************************************************
    // One-cycle enable every MS_CYCLES clocks
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            div_ff  <= '0;
            tick_ff <= 1'b0;
        end else if (div_ff == 32'(MS_CYCLES - 1)) begin
            div_ff  <= '0;
            tick_ff <= 1'b1;
        end else begin
            div_ff  <= div_ff + 32'h1;
            tick_ff <= 1'b0;
        end
    end

    // ****************************************************
    // Tx input loss filters
    // ****************************************************
    generate
        for (genvar i = 0; i < N_LANE; i++) begin : g_flt
            // Loss asserts after the assert filter, releases after
            // the longer release filter; agreement restarts the count
            always_ff @(posedge clk_in or posedge rst_in) begin
                if (rst_in) begin
                    flt_ff[i]  <= '0;
                    loss_ff[i] <= 1'b0;
                end else if (amp_low_s[i] == loss_ff[i]) begin
                    flt_ff[i] <= '0;
                end else if (tick_ff) begin
                    if (flt_ff[i] == (loss_ff[i] ? TX_REL_FLT_MS
                                                 : TX_LOSS_FLT_MS)) begin
                        loss_ff[i] <= amp_low_s[i];
                        flt_ff[i]  <= '0;
                    end else begin
                        flt_ff[i] <= flt_ff[i] + 11'h001;
                    end
                end
            end

            // Loss of a port squelches every lane mapped to it
            assign rx_sq_w[i] = los_s[RX_LANE_PORT[i*PW +: PW]]
                                && !rx_sqdis_ff;

            // Any lost feeding lane squelches the optical output
            assign tx_sq_w[i] = |(loss_ff & TX_FEED[i*N_LANE +: N_LANE])
                                && !tx_sqdis_ff;
        end
    endgenerate

    // ****************************************************
    // Lane driver controls
    // ****************************************************
    // Rx drivers off on squelch or host disable
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rx_en_ff <= '0;
        end else begin
            rx_en_ff <= ~(rx_sq_w | rx_odis_ff);
        end
    end

    // Squelch style follows how the off state is defined
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            off_ff <= '1;
            oma_ff <= '0;
        end else begin
            off_ff <= tx_dis_ff
                      | (tx_sq_w & {N_LANE{off_by_power_in}});
            oma_ff <= tx_sq_w & ~tx_dis_ff
                      & {N_LANE{!off_by_power_in}};
        end
    end

    // Detector threshold by lane rate class
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            thr_ff <= THR_LO;
        end else begin
            thr_ff <= (rate_class_in == RATE_HI) ? THR_HI : THR_LO;
        end
    end

    // ****************************************************
    // Tx disable deadline
    // ****************************************************
    // A changed disable write starts a watch; turning a lane off
    // uses the off limit, otherwise the on limit
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            start_ff <= 1'b0;
            lim_ff   <= TXDIS_ON_MS;
        end else begin
            start_ff <= stop_w && (tx_disable_in != tx_dis_ff);
            // Limit only moves with a watch start, never mid-watch,
            // so a STOP for other controls cannot shorten a watch
            if (stop_w && (tx_disable_in != tx_dis_ff)) begin
                if (|(tx_disable_in & ~tx_dis_ff)) begin
                    lim_ff <= eff_limit(advertised_tx_off_limit_in,
                                        fast_mode_adv_in ? TXDIS_ONF_MS
                                                         : TXDIS_ON_MS,
                                        mgmt_rev4_in);
                end else begin
                    lim_ff <= eff_limit(advertised_tx_on_limit_in,
                                        fast_mode_adv_in ? TXDIS_OFFF_MS
                                                         : TXDIS_OFF_MS,
                                        mgmt_rev4_in);
                end
            end
        end
    end

    assign dl.start = start_ff;
    assign dl.limit = lim_ff;
    assign dl.tick  = tick_ff;
    assign dl.met   = (pwr_ok_s == ~off_ff);

    lssd_deadline u_deadline (
        .clk_in (clk_in),
        .rst_in (rst_in),
        .dl     (dl.wd)
    );

    // Busy copy and sticky miss; a new miss beats a clear
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            busy_ff <= 1'b0;
            miss_ff <= 1'b0;
        end else begin
            busy_ff <= dl.active;
            miss_ff <= dl.miss | (miss_ff & !tx_miss_clr_in);
        end
    end

    // ****************************************************
    // Outputs
    // ****************************************************
    assign rx_out_en_out          = rx_en_ff;
    assign tx_laser_off_out       = off_ff;
    assign tx_low_oma_out         = oma_ff;
    assign tx_sq_threshold_out    = thr_ff;
    assign tx_input_loss_flag_out = loss_ff;
    assign tx_busy_out            = busy_ff;
    assign tx_miss_out            = miss_ff;

    // ****************************************************
    // Checks
    // ****************************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    sequence s_stop_write;
        stop_w;
    endsequence

    // Commit cycle, then the cycle in which the drivers show it
    sequence s_drivers_follow;
        1'b1 ##1 1'b1;
    endsequence

    a_ctl_commit: assert property (s_stop_write |=>
        tx_dis_ff == $past(tx_disable_in)
        && rx_odis_ff == $past(rx_out_disable_in))
        else $error("controls not taken at STOP");
    a_ctl_hold: assert property (!stop_w |=>
        $stable(tx_dis_ff) && $stable(rx_sqdis_ff))
        else $error("controls changed without STOP");
    a_txdis_out: assert property (s_stop_write ##1 s_drivers_follow |->
        (tx_laser_off_out & $past(tx_disable_in, 2))
        == $past(tx_disable_in, 2))
        else $error("disabled lane still lit");
    a_rx_odis: assert property (s_stop_write ##1 s_drivers_follow |->
        (rx_out_en_out & $past(rx_out_disable_in, 2)) == '0)
        else $error("disabled Rx lane still driven");
    a_sqdis_rx: assert property ((rx_sqdis_ff && rx_odis_ff == '0)
        |=> rx_out_en_out == '1)
        else $error("Rx squelched while squelch off");
    a_thr_rate: assert property (rate_class_in == RATE_HI
        |=> tx_sq_threshold_out == THR_HI)
        else $error("wrong squelch threshold");
    a_miss_sticky: assert property (dl.miss |=> tx_miss_out)
        else $error("deadline miss lost");

    // Clear without a new miss drops the sticky flag
    a_miss_clear: assert property
        (tx_miss_out && tx_miss_clr_in && !dl.miss |=> !tx_miss_out)
        else $error("deadline miss not cleared");

    // Tx squelch off and nothing disabled leaves every laser alone
    a_txsq_off: assert property
        (tx_sqdis_ff && tx_dis_ff == '0
         |=> tx_laser_off_out == '0 && tx_low_oma_out == '0)
        else $error("Tx squelched while squelch off");

    // Filtered loss may only move on a millisecond tick
    a_flag_tick: assert property
        ($changed(tx_input_loss_flag_out) |-> $past(tick_ff))
        else $error("loss flag moved off a tick");

    generate
        for (genvar k = 0; k < N_LANE; k++) begin : g_chk
            a_rx_squelch: assert property
                (los_s[RX_LANE_PORT[k*PW +: PW]] && !rx_sqdis_ff
                 |=> !rx_out_en_out[k])
                else $error("Rx lane not squelched");
            a_tx_squelch: assert property
                (|(loss_ff & TX_FEED[k*N_LANE +: N_LANE]) && !tx_sqdis_ff
                 |=> tx_laser_off_out[k] || tx_low_oma_out[k])
                else $error("Tx output not squelched");
        end
    endgenerate

endmodule : lssd_top

/* include/lssd_pkg.sv */
// Constants and types for the lane squelch and disable control block.
// Assumes one 250 MHz clock and host controls from a same-clock register core.

package lssd_pkg;

    // ****************************************************
    // Sizes
    // ****************************************************
    localparam int N_LANE = 8;               // Electrical lanes
    localparam int N_PORT = 8;               // Optical ports
    localparam int PW     = 3;               // Port index width
    localparam int MSW    = 11;              // Millisecond count width
    localparam int N_SYNC = 3 + N_PORT + 2 * N_LANE; // Synced pins

    // ****************************************************
    // Clock and millisecond tick
    // ****************************************************
    localparam int CLK_PERIOD_NS = 4;        // 250 MHz
    localparam int MS_NS         = 1000000;  // One millisecond
    localparam int MS_CYC_DEF    = MS_NS / CLK_PERIOD_NS;

    typedef logic [MSW-1:0] lssd_ms_t;       // Count of milliseconds

    // ****************************************************
    // Deadlines in milliseconds
    // ****************************************************
    localparam lssd_ms_t RX_SQ_ON_MS  = 11'h00F; // 15 ms
    localparam lssd_ms_t TX_SQ_ON_MS  = 11'h190; // 400 ms
    localparam lssd_ms_t TX_SQ_OFF_MS = 11'h5DC; // 1.5 s
    localparam lssd_ms_t TXDIS_ON_MS  = 11'h064; // 100 ms
    localparam lssd_ms_t TXDIS_ONF_MS = 11'h003; // 3 ms
    localparam lssd_ms_t TXDIS_OFF_MS = 11'h190; // 400 ms
    localparam lssd_ms_t TXDIS_OFFF_MS = 11'h00A; // 10 ms
    localparam lssd_ms_t RXDIS_MS     = 11'h064; // 100 ms
    localparam lssd_ms_t SQDIS_MS     = 11'h064; // 100 ms

    // Tx loss filter times, well inside the Tx squelch deadlines above
    localparam lssd_ms_t TX_LOSS_FLT_MS = 11'h002; // Assert filter
    localparam lssd_ms_t TX_REL_FLT_MS  = 11'h00A; // Release filter

    // ****************************************************
    // Lane maps and thresholds
    // ****************************************************
    // Rx lane i is fed by optical port RX_LANE_PORT[i*PW +: PW]
    localparam logic [N_LANE*PW-1:0] RX_LANE_PORT = 24'hFAC688;
    // Optical output k is fed by electrical lanes TX_FEED[k*N_LANE +: N_LANE]
    localparam logic [N_LANE*N_LANE-1:0] TX_FEED =
        64'h8040201008040201;
    localparam logic [1:0] RATE_HI = 2'h2;   // Highest lane rate class
    localparam logic [7:0] THR_LO  = 8'h46;  // 70 mV peak-to-peak
    localparam logic [7:0] THR_HI  = 8'h32;  // 50 mV peak-to-peak

endpackage : lssd_pkg

/* include/lssd_dl_if.sv */
// Handshake between the control block and its deadline watcher.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps

interface lssd_dl_if;
    import lssd_pkg::*;
    logic     start;   // One-cycle pulse, begin watching
    lssd_ms_t limit;   // Deadline in milliseconds
    logic     met;     // Output has reached requested state
    logic     tick;    // One-cycle millisecond enable
    logic     active;  // Watch in progress
    logic     miss;    // One-cycle pulse, deadline passed

    modport ctl (output start, limit, met, tick, input active, miss);
    modport wd  (input start, limit, met, tick, output active, miss);
endinterface : lssd_dl_if

/* rtl/lssd_deadline.sv */
// Deadline watcher: counts millisecond ticks after a start pulse.
// Assumes limit is held steady while active and is at least one.
`timescale 1ns/1ps

module lssd_deadline (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Control side
    lssd_dl_if.wd    dl
);
    import lssd_pkg::*;

    lssd_ms_t cnt_ff;     // Milliseconds elapsed
    logic     active_ff;  // Watch running
    logic     miss_ff;    // Miss pulse

    assign dl.active = active_ff;
    assign dl.miss   = miss_ff;

    // ****************************************************
    // Watch state
    // ****************************************************
    // Start restarts, met ends quietly, limit ticks end with a miss
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            active_ff <= 1'b0;
            cnt_ff    <= '0;
            miss_ff   <= 1'b0;
        end else begin
            miss_ff <= 1'b0;
            if (dl.start) begin
                active_ff <= 1'b1;
                cnt_ff    <= '0;
            end else if (active_ff && dl.met) begin
                active_ff <= 1'b0;
            end else if (active_ff && dl.tick) begin
                if (cnt_ff == dl.limit - 11'h001) begin
                    active_ff <= 1'b0;
                    miss_ff   <= 1'b1;
                end else begin
                    cnt_ff <= cnt_ff + 11'h001;
                end
            end
        end
    end

    // ****************************************************
    // Checks
    // ****************************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    a_wd_start: assert property (dl.start |=> active_ff && cnt_ff == '0)
        else $error("watch did not start");
    a_wd_met: assert property
        (active_ff && dl.met && !dl.start |=> !active_ff && !miss_ff)
        else $error("met state still flagged");
    a_wd_bound: assert property (active_ff |-> cnt_ff < dl.limit)
        else $error("watch ran past its limit");

endmodule : lssd_deadline

/* verif/lssd_host_model.sv */
// Host side of the management bus: module select and STOP framing.
// Assumes the bus pins are sampled by the module on clk_in.
`timescale 1ns/1ps

module lssd_host_model #(
    parameter int MS_CYCLES = 10 // Cycles per millisecond
) (
    // Clock
    input  wire logic clk_in,      // Module clock
    // Bus pins
    output logic      scl_out,     // Bus clock, idles high
    output logic      sda_out,     // Bus data, idles high
    output logic      sel_n_out    // Module select, active low
);
    // ****************************************************
    // Idle bus: pull-ups hold both lines high
    // ****************************************************
    initial begin
        scl_out   = 1'b1;
        sda_out   = 1'b1;
        sel_n_out = 1'b1;
    end

    // ****************************************************
    // Write ending in a STOP, select held around it
    // ****************************************************
    task automatic stop_write();
        sel_n_out <= 1'b0;
        repeat (2 * MS_CYCLES) @(posedge clk_in);
        sda_out <= 1'b0;
        repeat (4) @(posedge clk_in);
        sda_out <= 1'b1;
        repeat (2 * MS_CYCLES) @(posedge clk_in);
        sel_n_out <= 1'b1;
        @(posedge clk_in);                        // Bus rests a cycle
    endtask : stop_write

    // ****************************************************
    // Edges that must not commit: STOP while deselected,
    // then data moving while the bus clock is low
    // ****************************************************
    task automatic stray_edges();
        sda_out <= 1'b0;
        repeat (4) @(posedge clk_in);
        sda_out <= 1'b1;
        repeat (4) @(posedge clk_in);
        scl_out   <= 1'b0;
        sel_n_out <= 1'b0;
        repeat (2 * MS_CYCLES) @(posedge clk_in);
        sda_out <= 1'b0;
        repeat (4) @(posedge clk_in);
        sda_out <= 1'b1;
        repeat (4) @(posedge clk_in);
        scl_out <= 1'b1;
        repeat (2 * MS_CYCLES) @(posedge clk_in);
        sel_n_out <= 1'b1;
        @(posedge clk_in);                        // Bus rests a cycle
    endtask : stray_edges
endmodule : lssd_host_model

/* verif/lssd_top_test.sv */
// Self-checking bench for the lane squelch and disable control block.
// Assumes a 10-cycle millisecond so deadlines stay short.
`timescale 1ns/1ps

module lssd_top_test;
    import lssd_pkg::*;
    localparam int MS = 10;             // Cycles per ms in simulation
    logic       clk, rst, scl, sda, sel_n, rsq, tsq, clr, fast, rev4;
    logic       opw, busy, miss, stall;
    logic [1:0] rate;                   // Lane rate class
    logic [7:0] tdis, rdis, los, amp, pok, ren, loff, oma, thr, flag;
    int         n_fail, checks_done;    // Mismatches and comparisons

    lssd_host_model #(.MS_CYCLES(MS)) lssd_host_model_inst (
        .clk_in(clk), .scl_out(scl), .sda_out(sda), .sel_n_out(sel_n));
    lssd_top #(.MS_CYCLES(MS)) lssd_top_inst (
        .clk_in(clk), .rst_in(rst), .scl_in(scl), .sda_in(sda),
        .module_select_n_in(sel_n), .tx_disable_in(tdis),
        .rx_out_disable_in(rdis), .rx_sq_disable_in(rsq),
        .tx_sq_disable_in(tsq), .tx_miss_clr_in(clr),
        .fast_mode_adv_in(fast), .mgmt_rev4_in(rev4),
        .off_by_power_in(opw), .rate_class_in(rate),
        .advertised_tx_off_limit_in(11'h006),
        .advertised_tx_on_limit_in(11'h014), .rx_los_in(los),
        .tx_amp_low_in(amp), .tx_power_ok_in(pok), .rx_out_en_out(ren),
        .tx_laser_off_out(loff), .tx_low_oma_out(oma),
        .tx_sq_threshold_out(thr), .tx_input_loss_flag_out(flag),
        .tx_busy_out(busy), .tx_miss_out(miss));

    // Clock, 4 ns period
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Laser follows its off control unless stalled
    always @(posedge clk) begin
        if (rst) pok <= 8'h00;
        else if (!stall) pok <= ~loff;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic ms(input int n);
        repeat (n * MS) @(posedge clk);
    endtask : ms

    task automatic stop();
        lssd_host_model_inst.stop_write();
    endtask : stop

    // Disable one lane with the laser stuck lit, expect a miss
    task automatic miss_case(input logic f, input logic r, input int lim);
        fast  <= f;
        rev4  <= r;
        stall <= 1'b1;
        tdis  <= 8'h80;
        stop();
        if (lim > 4) chk(busy, 1'b1);
        if (lim > 4) chk(miss, 1'b0);
        ms(lim - 1);
        chk(miss, 1'b1);
        clr <= 1'b1;
        ms(1);
        clr <= 1'b0;
        chk(miss, 1'b0);
        stall <= 1'b0;
        tdis  <= 8'h00;
        stop();
        $display("deadline case done, limit %0d ms", lim);
    endtask : miss_case

    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : test_done

    initial begin
        {rst, rsq, tsq, clr, fast, rev4, opw, stall} = 8'h82;
        {tdis, rdis, los, amp} = 32'h0;
        rate = 2'h0;
        n_fail = 0;
        checks_done = 0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        ms(1);
        chk(ren, 8'hFF);
        chk(loff, 8'h00);
        for (int r = 0; r < 4; r++) begin
            rate <= r[1:0];
            ms(1);
            chk(thr, (r == 2) ? 8'h32 : 8'h46);
        end
        los <= 8'h81;
        rsq <= 1'b1;
        ms(15);
        chk(ren, 8'h7E);
        stop();
        chk(ren, 8'hFF);
        rsq <= 1'b0;
        stop();
        chk(ren, 8'h7E);
        los  <= 8'h00;
        rdis <= 8'h0F;
        stop();
        chk(ren, 8'hF0);
        rdis <= 8'h00;
        stop();
        chk(ren, 8'hFF);
        rdis <= 8'hFF;
        lssd_host_model_inst.stray_edges();
        chk(ren, 8'hFF);
        rdis <= 8'h00;
        $display("rx tests done");
        amp <= 8'h04;
        ms(TX_LOSS_FLT_MS + 3);
        chk(flag, 8'h04);
        chk(loff, 8'h04);
        opw <= 1'b0;
        ms(1);
        chk(oma, 8'h04);
        tsq <= 1'b1;
        stop();
        chk(oma, 8'h00);
        tsq <= 1'b0;
        stop();
        chk(oma, 8'h04);
        amp <= 8'h00;
        ms(TX_REL_FLT_MS + 3);
        chk(flag, 8'h00);
        chk(oma, 8'h00);
        tdis <= 8'h01;
        stop();
        chk(loff, 8'h01);
        tdis <= 8'h00;
        stop();
        chk(loff, 8'h00);
        $display("tx tests done");
        miss_case(1'b1, 1'b0, 3);
        miss_case(1'b0, 1'b1, 6);
        miss_case(1'b0, 1'b0, 100);
        test_done();
    end
endmodule : lssd_top_test
